// file: verilog/hbspi_pkg.sv
// Constants shared by the half-bridge SPI control register bank and its testbench.
// Assumes a single 20 MHz system clock and SPI pins synchronous to it.
package hbspi_pkg;

    // ************************************************************
    // Frame layout
    // ************************************************************
    localparam int         FRAME_BITS    = 16;
    localparam int         BYTE_BITS     = 8;
    localparam int         OP_BIT        = 7;
    localparam int         SEL_MSB       = 6;
    localparam int         SEL_LSB       = 4;
    localparam int         FIXED_MSB     = 3;
    localparam int         FIXED_LSB     = 2;
    localparam int         LAST_ADDRESS_TOKEN_BIT      = 1;
    localparam int         TAIL_BIT      = 0;
    localparam logic [1:0] FIXED_VAL     = 2'h0;
    localparam logic       TAIL_VAL      = 1'b1;

    // ************************************************************
    // Register selection codes and reset values
    // ************************************************************
    localparam int         NUM_REGS      = 8;
    localparam logic [2:0] SEL_HB_EN_A   = 3'h0;
    localparam logic [2:0] SEL_CONFIG    = 3'h5;
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam logic [7:0] CONFIG_RESET  = 8'h03;
    localparam logic [7:0] IDLE_RESPONSE = 8'h00;

    // ************************************************************
    // Enable register field layout: pair k holds output k+1
    // ************************************************************
    localparam int         NUM_BRIDGES   = 4;
    localparam int         HS_OFFSET     = 1;
    localparam int         LS_OFFSET     = 0;

    typedef enum logic [2:0]
    {
        HBSPI_IDLE = 3'b001,
        HBSPI_ADDR = 3'b010,
        HBSPI_DATA = 3'b100
    } hbspi_state_t;

endpackage

// file: verilog/hbspi_interlock.sv
// One half-bridge output stage: turns both switches off when both are requested.
// Assumes the requests come straight from a control register.
`timescale 1ns/1ps
module hbspi_interlock
(
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic hs_req,
    input  wire logic ls_req,
    output logic      hs_on_r,
    output logic      ls_on_r
);

    logic hs_on_nxt;
    logic ls_on_nxt;

    // ************************************************************
    // Cross-current interlock
    // ************************************************************
    // Both requests together leave the bridge fully off rather than picking a winner.
    always_comb
    begin
        hs_on_nxt = hs_req & ~ls_req;
        ls_on_nxt = ls_req & ~hs_req;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            hs_on_r <= 1'b0;
            ls_on_r <= 1'b0;
        end
        else
        begin
            hs_on_r <= hs_on_nxt;
            ls_on_r <= ls_on_nxt;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    property p_no_cross;
        @(posedge clk_sys) disable iff (rst)
        (hs_req && ls_req) |=> (!hs_on_r && !ls_on_r);
    endproperty
    a_no_cross: assert property (p_no_cross) else $error("Both switches of a bridge were on.");

    property p_single_on;
        @(posedge clk_sys) disable iff (rst)
        (hs_req != ls_req) |=> (hs_on_r == $past(hs_req) && ls_on_r == $past(ls_req));
    endproperty
    a_single_on: assert property (p_single_on) else $error("Single enable did not reach its switch.");

endmodule

// file: verilog/hbspi_regbank.sv
// SPI-reached control register bank of a half-bridge driver, with the output enables.
// Assumes SPI mode 0 pins synchronous to clk_sys and at most a quarter of its rate.
`timescale 1ns/1ps
module hbspi_regbank
#(
    parameter int NUM_BRIDGES = hbspi_pkg::NUM_BRIDGES
)
(
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire logic                   spi_sclk,
    input  wire logic                   spi_cs_n,
    input  wire logic                   spi_mosi,
    output logic                        spi_miso,
    output logic                        spi_miso_oe,
    output logic [NUM_BRIDGES-1:0]      high_switch_on,
    output logic [NUM_BRIDGES-1:0]      low_switch_on,
    output logic [7:0]                  config_q
);

    // ************************************************************
    // Declarations
    // ************************************************************
    hbspi_pkg::hbspi_state_t state_r;
    hbspi_pkg::hbspi_state_t state_nxt;
    logic [7:0]              regs_r   [hbspi_pkg::NUM_REGS];
    logic [7:0]              regs_nxt [hbspi_pkg::NUM_REGS];
    logic                    sclk_q_r;
    logic [15:0]             shift_r;
    logic [15:0]             shift_nxt;
    logic [4:0]              count_r;
    logic [4:0]              count_nxt;
    logic [7:0]              tx_r;
    logic [7:0]              tx_nxt;
    logic                    miso_r;
    logic                    miso_nxt;
    logic                    oe_r;
    logic                    oe_nxt;
    logic                    sclk_rise;
    logic                    sclk_fall;
    logic [7:0]              addr_byte;
    logic [7:0]              next_addr;
    logic                    addr_ok;
    logic                    next_addr_ok;
    logic [2:0]              sel;
    logic [2:0]              next_sel;
    logic                    commit;

    assign sclk_rise    = spi_sclk & ~sclk_q_r;
    assign sclk_fall    = ~spi_sclk & sclk_q_r;
    assign addr_byte    = shift_r[15:8];
    assign next_addr    = {shift_r[6:0], spi_mosi};
    assign sel          = addr_byte[hbspi_pkg::SEL_MSB:hbspi_pkg::SEL_LSB];
    assign next_sel     = next_addr[hbspi_pkg::SEL_MSB:hbspi_pkg::SEL_LSB];
    // The token bit does not take part in decoding; the trailing bit and the fixed field do.
    assign addr_ok      = addr_byte[hbspi_pkg::FIXED_MSB:hbspi_pkg::FIXED_LSB] == hbspi_pkg::FIXED_VAL
                          && addr_byte[hbspi_pkg::TAIL_BIT] == hbspi_pkg::TAIL_VAL;
    assign next_addr_ok = next_addr[hbspi_pkg::FIXED_MSB:hbspi_pkg::FIXED_LSB] == hbspi_pkg::FIXED_VAL
                          && next_addr[hbspi_pkg::TAIL_BIT] == hbspi_pkg::TAIL_VAL;
    // A write lands only when the frame closes with exactly sixteen bits, so a cut frame is harmless.
    assign commit       = state_r == hbspi_pkg::HBSPI_DATA && spi_cs_n
                          && count_r == 5'(hbspi_pkg::FRAME_BITS)
                          && addr_byte[hbspi_pkg::OP_BIT] && addr_ok;

    // ************************************************************
    // Frame engine
    // ************************************************************
    always_comb
    begin
        state_nxt = state_r;
        shift_nxt = shift_r;
        count_nxt = count_r;
        tx_nxt    = tx_r;
        miso_nxt  = miso_r;
        oe_nxt    = ~spi_cs_n;
        unique case (state_r)
            hbspi_pkg::HBSPI_IDLE:
            begin
                if (!spi_cs_n)
                begin
                    state_nxt = hbspi_pkg::HBSPI_ADDR;
                    count_nxt = 5'h00;
                    miso_nxt  = hbspi_pkg::IDLE_RESPONSE[7];
                    tx_nxt    = hbspi_pkg::IDLE_RESPONSE;
                end
            end
            hbspi_pkg::HBSPI_ADDR:
            begin
                if (spi_cs_n)
                begin
                    state_nxt = hbspi_pkg::HBSPI_IDLE;
                end
                else if (sclk_rise)
                begin
                    shift_nxt = {shift_r[14:0], spi_mosi};
                    count_nxt = count_r + 5'h01;
                    if (count_r == 5'(hbspi_pkg::BYTE_BITS - 1))
                    begin
                        state_nxt = hbspi_pkg::HBSPI_DATA;
                        tx_nxt    = next_addr_ok ? regs_r[next_sel] : hbspi_pkg::IDLE_RESPONSE;
                    end
                end
            end
            hbspi_pkg::HBSPI_DATA:
            begin
                if (spi_cs_n)
                begin
                    state_nxt = hbspi_pkg::HBSPI_IDLE;
                end
                else if (sclk_rise)
                begin
                    shift_nxt = {shift_r[14:0], spi_mosi};
                    if (count_r != 5'(hbspi_pkg::FRAME_BITS + 1))
                    begin
                        count_nxt = count_r + 5'h01;
                    end
                end
                else if (sclk_fall && count_r <= 5'(hbspi_pkg::FRAME_BITS - 1))
                begin
                    miso_nxt = tx_r[7];
                    tx_nxt   = {tx_r[6:0], 1'b0};
                end
            end
            default:
            begin
                state_nxt = hbspi_pkg::HBSPI_IDLE;
            end
        endcase
    end

    // ************************************************************
    // Control registers
    // ************************************************************
    always_comb
    begin
        for (int i = 0; i < hbspi_pkg::NUM_REGS; i++)
        begin
            regs_nxt[i] = regs_r[i];
        end
        if (commit)
        begin
            regs_nxt[sel] = shift_r[7:0];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_r  <= hbspi_pkg::HBSPI_IDLE;
            sclk_q_r <= 1'b0;
            shift_r  <= 16'h0000;
            count_r  <= 5'h00;
            tx_r     <= 8'h00;
            miso_r   <= 1'b0;
            oe_r     <= 1'b0;
            for (int i = 0; i < hbspi_pkg::NUM_REGS; i++)
            begin
                regs_r[i] <= (3'(i) == hbspi_pkg::SEL_CONFIG) ? hbspi_pkg::CONFIG_RESET
                                                              : hbspi_pkg::CTRL_RESET;
            end
        end
        else
        begin
            state_r  <= state_nxt;
            sclk_q_r <= spi_sclk;
            shift_r  <= shift_nxt;
            count_r  <= count_nxt;
            tx_r     <= tx_nxt;
            miso_r   <= miso_nxt;
            oe_r     <= oe_nxt;
            for (int i = 0; i < hbspi_pkg::NUM_REGS; i++)
            begin
                regs_r[i] <= regs_nxt[i];
            end
        end
    end

    assign spi_miso    = miso_r;
    assign spi_miso_oe = oe_r;

    // ************************************************************
    // Configuration output register
    // ************************************************************
    logic [7:0] config_r;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            config_r <= hbspi_pkg::CONFIG_RESET;
        end
        else
        begin
            config_r <= regs_r[hbspi_pkg::SEL_CONFIG];
        end
    end

    assign config_q = config_r;

    // ************************************************************
    // Output stages
    // ************************************************************
    for (genvar k = 0; k < NUM_BRIDGES; k++)
    begin : g_bridge
        hbspi_interlock u_il
        (
            .clk_sys (clk_sys),
            .rst     (rst),
            .hs_req  (regs_r[hbspi_pkg::SEL_HB_EN_A][2*k+hbspi_pkg::HS_OFFSET]),
            .ls_req  (regs_r[hbspi_pkg::SEL_HB_EN_A][2*k+hbspi_pkg::LS_OFFSET]),
            .hs_on_r (high_switch_on[k]),
            .ls_on_r (low_switch_on[k])
        );
    end

    // ************************************************************
    // Checks
    // ************************************************************
    logic [7:0] en_a;
    assign en_a = regs_r[hbspi_pkg::SEL_HB_EN_A];

    property p_reset_zero;
        @(posedge clk_sys) $fell(rst) |-> (en_a == 8'h00 && regs_r[0] == 8'h00 && high_switch_on == '0);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("Control register not zero after reset.");

    property p_reset_config;
        @(posedge clk_sys) $fell(rst) |-> regs_r[hbspi_pkg::SEL_CONFIG] == 8'h03 ##1 config_q == 8'h03;
    endproperty
    a_reset_config: assert property (p_reset_config) else $error("Configuration not 0x03 after reset.");

    property p_hold;
        @(posedge clk_sys) disable iff (rst)
        !commit |=> $stable(en_a) && $stable(regs_r[hbspi_pkg::SEL_CONFIG]);
    endproperty
    a_hold: assert property (p_hold) else $error("Register changed without a write frame.");

    property p_read_keeps;
        @(posedge clk_sys) disable iff (rst)
        (state_r == hbspi_pkg::HBSPI_DATA && !addr_byte[hbspi_pkg::OP_BIT]) |=> $stable(en_a);
    endproperty
    a_read_keeps: assert property (p_read_keeps) else $error("Read frame altered a register.");

    property p_write_lands;
        @(posedge clk_sys) disable iff (rst)
        commit |=> regs_r[$past(sel)] == $past(shift_r[7:0]);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("Write data did not land.");

    property p_frame_len;
        @(posedge clk_sys) disable iff (rst)
        commit |-> count_r == 5'h10 && addr_byte[0];
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("Write taken from a bad frame.");

    // The reply line must carry the idle pattern while the address byte is still arriving.
    property p_addr_quiet;
        @(posedge clk_sys) disable iff (rst)
        state_r == hbspi_pkg::HBSPI_ADDR |-> spi_miso == hbspi_pkg::IDLE_RESPONSE[7];
    endproperty
    a_addr_quiet: assert property (p_addr_quiet) else $error("Reply line not quiet in address byte.");

    property p_tx_load;
        @(posedge clk_sys) disable iff (rst)
        (state_r == hbspi_pkg::HBSPI_ADDR && !spi_cs_n && sclk_rise && count_r == 5'h07 && next_addr_ok)
        |=> tx_r == regs_r[$past(next_sel)];
    endproperty
    a_tx_load: assert property (p_tx_load) else $error("Read byte not loaded for reply.");

    property p_oe;
        @(posedge clk_sys) disable iff (rst)
        spi_cs_n |=> !spi_miso_oe;
    endproperty
    a_oe: assert property (p_oe) else $error("Serial output driven while deselected.");

    property p_map;
        @(posedge clk_sys) disable iff (rst)
        (en_a[7] && !en_a[6]) |=> high_switch_on[3] && !low_switch_on[3];
    endproperty
    a_map: assert property (p_map) else $error("Output 4 high enable not mapped to D7.");

    c_write: cover property (@(posedge clk_sys) disable iff (rst) commit && sel == hbspi_pkg::SEL_HB_EN_A);
    c_read: cover property (@(posedge clk_sys) disable iff (rst)
        state_r == hbspi_pkg::HBSPI_DATA && spi_cs_n && !addr_byte[hbspi_pkg::OP_BIT]);
    c_cross: cover property (@(posedge clk_sys) disable iff (rst) en_a[1] && en_a[0]);

endmodule

// file: tb/hbspi_host.sv
// SPI master model of the host that programs the half-bridge register bank.
// Assumes mode 0 framing and the same system clock that the bank samples with.
`timescale 1ns/1ps
module hbspi_host
(
    input  wire logic       clk_sys,
    input  wire logic       spi_miso,
    input  wire logic       spi_miso_oe,
    output logic            spi_sclk,
    output logic            spi_cs_n,
    output logic            spi_mosi,
    output logic [7:0]      rx_byte,
    output logic            rx_done
);
    // The reply line has a pull-up, so a released pin reads high, never a stale bit.
    logic miso_line;
    assign miso_line = spi_miso_oe ? spi_miso : 1'b1;

    initial
    begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
        rx_byte  = 8'h00;
        rx_done  = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask

    // Three clocks per half period keep the bank's two-sample minimum with margin.
    task automatic frame(input logic [16:0] tx, input int nbits, input logic rd);
        int i;
        tick(1);
        spi_cs_n = 1'b0;
        for (i = nbits - 1; i >= 0; i--)
        begin
            spi_mosi = tx[i];
            tick(3);
            if (nbits - 1 - i >= 8)
                rx_byte = {rx_byte[6:0], miso_line};
            spi_sclk = 1'b1;
            tick(3);
            spi_sclk = 1'b0;
        end
        tick(3);
        spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
        tick(1);
        rx_done = rd;
        tick(1);
        rx_done = 1'b0;
        tick(1);
    endtask
endmodule

// file: tb/hbspi_regbank_tb.sv
// Self-checking bench of the half-bridge register bank, driven through the host model.
// Assumes the bank's registered outputs and its one-clock reply lag.
`timescale 1ns/1ps
module hbspi_regbank_tb;
    localparam int MAX_CYCLES = 40000;
    logic       clk_sys;
    logic       rst;
    logic       spi_sclk;
    logic       spi_cs_n;
    logic       spi_mosi;
    logic       spi_miso;
    logic       spi_miso_oe;
    logic [3:0] high_switch_on;
    logic [3:0] low_switch_on;
    logic [7:0] config_q;
    logic [7:0] rx_byte;
    logic       rx_done;
    logic [7:0] exp_reg [8];
    logic [7:0] sw_q [$];
    logic [7:0] cfg_q [$];
    logic [7:0] rd_q [$];
    logic [7:0] sw_last;
    logic [7:0] cfg_last;
    logic [7:0] v;
    logic       watch;
    int         bad_count;
    int         n_tests;
    int         cycles;

    hbspi_regbank #(.NUM_BRIDGES(hbspi_pkg::NUM_BRIDGES)) dut
    (
        .clk_sys(clk_sys), .rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
        .high_switch_on(high_switch_on), .low_switch_on(low_switch_on), .config_q(config_q)
    );
    hbspi_host host
    (
        .clk_sys(clk_sys), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .rx_byte(rx_byte), .rx_done(rx_done)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // ****************************************
    // Expectations and comparison
    // ****************************************
    function automatic logic [7:0] sw_of(input logic [7:0] b);
        logic [7:0] r;
        for (int k = 0; k < 4; k++)
        begin
            r[4+k] = b[2*k+1] & ~b[2*k];
            r[k]   = b[2*k] & ~b[2*k+1];
        end
        return r;
    endfunction

    function automatic logic [7:0] adr(input logic op, input logic [2:0] sel, input logic tok);
        return {op, sel, 2'h0, tok, 1'b1};
    endfunction

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles >= MAX_CYCLES)
        begin
            bad_count++;
            results();
        end
        else if (watch)
        begin
            if (rx_done === 1'b1)
                check("read reply", rd_q.size() ? rd_q.pop_front() : 8'hXX, rx_byte);
            if ({high_switch_on, low_switch_on} !== sw_last)
            begin
                check("switches", sw_q.size() ? sw_q.pop_front() : 8'hXX,
                      {high_switch_on, low_switch_on});
                sw_last = {high_switch_on, low_switch_on};
            end
            if (config_q !== cfg_last)
            begin
                check("config", cfg_q.size() ? cfg_q.pop_front() : 8'hXX, config_q);
                cfg_last = config_q;
            end
        end
    end

    // ****************************************
    // Register access
    // ****************************************
    task automatic xfer(input logic [16:0] tx, input int n, input logic rd, input logic [7:0] exp);
        if (rd)
            rd_q.push_back(exp);
        host.frame(tx, n, rd);
    endtask

    task automatic wr(input logic [2:0] sel, input logic [7:0] d, input logic tok);
        if (sel == 3'h0 && sw_of(d) !== sw_of(exp_reg[0]))
            sw_q.push_back(sw_of(d));
        if (sel == hbspi_pkg::SEL_CONFIG && d !== exp_reg[5])
            cfg_q.push_back(d);
        exp_reg[sel] = d;
        xfer({1'b0, adr(1'b1, sel, tok), d}, 16, 1'b0, 8'h00);
    endtask

    task automatic rd(input logic [2:0] sel);
        xfer({1'b0, adr(1'b0, sel, 1'b0), 8'h00}, 16, 1'b1, exp_reg[sel]);
    endtask

    task automatic defaults();
        foreach (exp_reg[i])
            exp_reg[i] = 8'h00;
        exp_reg[5] = 8'h03;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial
    begin
        static logic [7:0] pats [6] = '{8'hFF, 8'hAA, 8'h55, 8'hC3, 8'h3C, 8'h00};
        rst = 1'b1;
        watch = 1'b0;
        sw_last = 8'h00;
        cfg_last = 8'h03;
        void'($urandom(68));
        defaults();
        repeat (10) @(posedge clk_sys);
        #2;
        rst = 1'b0;
        watch = 1'b1;
        for (int s = 0; s < 8; s++)
            rd(s[2:0]);
        foreach (pats[i])
        begin
            wr(3'h0, pats[i], 1'b0);
            rd(3'h0);
        end
        repeat (16)
        begin
            wr(3'h0, 8'($urandom), 1'($urandom));
            rd(3'h0);
            rd(3'h0);
        end
        for (int s = 0; s < 8; s++)
            wr(s[2:0], 8'($urandom), 1'b0);
        for (int s = 0; s < 8; s++)
            rd(s[2:0]);
        // Frames of the wrong length or with a bad fixed field or trailing bit must change nothing.
        v = ~exp_reg[0];
        xfer({2'h0, adr(1'b1, 3'h0, 1'b0), v[7:1]}, 15, 1'b0, 8'h00);
        xfer({adr(1'b1, 3'h0, 1'b0), v, 1'b0}, 17, 1'b0, 8'h00);
        xfer({1'b0, 8'h85, v}, 16, 1'b0, 8'h00);
        xfer({1'b0, 8'h80, v}, 16, 1'b0, 8'h00);
        xfer({1'b0, 8'h05, 8'h00}, 16, 1'b1, 8'h00);
        rd(3'h0);
        repeat (300) @(posedge clk_sys);
        #2;
        rd(3'h0);
        rd(3'h5);
        // A second reset in mid-run must bring every default back.
        wr(3'h0, 8'h81, 1'b0);
        wr(3'h5, 8'hF0, 1'b0);
        sw_q.push_back(8'h00);
        cfg_q.push_back(8'h03);
        defaults();
        rst = 1'b1;
        repeat (10) @(posedge clk_sys);
        #2;
        rst = 1'b0;
        for (int s = 0; s < 8; s++)
            rd(s[2:0]);
        repeat (5) @(posedge clk_sys);
        results();
    end
endmodule
